// ==== common/speech_packet_regs.vh ====
// constants for the speech packet rate interface: packet types, sizes, modes, timing
// assumes a 40 MHz system clock
`ifndef SPEECH_PACKET_REGS_VH
`define SPEECH_PACKET_REGS_VH

// packet type codes
`define PKT_FULL      3'h0
`define PKT_HALF      3'h1
`define PKT_QUARTER   3'h2
`define PKT_EIGHTH    3'h3
`define PKT_BLANK     3'h4
`define PKT_ERASURE   3'h5

// payload lengths in bits
`define BITS_FULL     9'h10a
`define BITS_HALF     9'h07c
`define BITS_QUARTER  9'h036
`define BITS_EIGHTH   9'h014
`define BITS_BLANK    9'h000

// speech classes
`define CLASS_SILENT     2'h0
`define CLASS_UNVOICED   2'h1
`define CLASS_VOICED     2'h2
`define CLASS_TRANSITION 2'h3

// mode-select field: bit 2 narrowband, bits 1:0 mode (3 = mode 2 half-rate max)
`define MODE_RESET    3'h0
`define MODE_NB_BIT   2
`define MODE_HRMAX    2'h3

// timing
`define CLOCK_HZ        40000000
`define FRAME_MS        20
`define INIT_MS         40
`define MUTE_MS         1000
`define SWITCH_MS       20
`define FRAME_CYCLES    (`CLOCK_HZ / 1000 * `FRAME_MS)
`define INIT_CYCLES     (`CLOCK_HZ / 1000 * `INIT_MS)
`define MUTE_FRAMES     (`MUTE_MS / `FRAME_MS)
`define SWITCH_FRAMES   (`SWITCH_MS / `FRAME_MS)

`endif

// ==== rtl/packet_fifo.v ====
// small synchronous fifo for outgoing packet descriptors
// assumes one clock and a synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none

module packet_fifo #(
  parameter WIDTH = 12,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  // clock and reset
  input  wire             clock_in,
  input  wire             rst_in,
  // fill side
  input  wire             in_valid_in,
  output wire             in_ready_out,
  input  wire [WIDTH-1:0] in_data_in,
  // drain side
  output wire             out_valid_out,
  input  wire             out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);

  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;
  wire            push;
  wire            pop;

  // full and empty come straight from the occupancy count
  assign in_ready_out  = (count_reg != DEPTH[AW:0]);
  assign out_valid_out = (count_reg != {(AW+1){1'b0}});
  assign out_data_out  = mem_reg[rd_ptr_reg];
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  //////////////////////////////////////////////////////////////////////////////
  // pointers and storage
  always @(posedge clock_in)
  begin
    if (rst_in)
    begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
      begin
        mem_reg[wr_ptr_reg] <= in_data_in;
        wr_ptr_reg          <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
      end
      if (pop)
        rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
      if (push & ~pop)
        count_reg <= count_reg + 1'b1;
      else if (pop & ~push)
        count_reg <= count_reg - 1'b1;
    end
  end

endmodule // packet_fifo

`default_nettype wire

// ==== rtl/speech_packet_rate_interface.v ====
// frame-level packet rate control between a speech codec and the multiplex sublayer
// assumes command and call-state inputs are synchronous to clock_in; the frame tick is internal
// assumes the sublayer drains descriptors within a frame; a 4-deep fifo absorbs short stalls
`timescale 1ns/100ps
`default_nettype none
`include "speech_packet_regs.vh"

module speech_packet_rate_interface #(
  parameter FRAME_CYCLES = `FRAME_CYCLES,
  parameter INIT_CYCLES  = `INIT_CYCLES,
  parameter MUTE_FRAMES  = `MUTE_FRAMES
) (
  // clock and reset
  input  wire        clock_in,
  input  wire        rst_in,
  // connection setup
  input  wire        action_time_in,
  input  wire        call_instance_in,
  input  wire        conversation_in,
  // per-frame commands from the sublayer
  input  wire        blank_cmd_in,
  input  wire        rate_limit_cmd_in,
  // speech class from the analysis front end
  input  wire [1:0]  speech_class_in,
  // control message
  input  wire        ctrl_msg_valid_in,
  input  wire [2:0]  encoding_mode_select_in,
  input  wire        peer_mobile_flag_in,
  input  wire        reinit_flag_in,
  // outgoing packet descriptors
  output wire        tx_valid_out,
  input  wire        tx_ready_in,
  output wire [2:0]  tx_type_out,
  output wire [8:0]  tx_bits_out,
  output wire        tx_all_ones_out,
  output wire        tx_overflow_out,
  // received packet from the sublayer
  input  wire        rx_valid_in,
  input  wire [2:0]  rx_type_in,
  output reg  [8:0]  rx_bits_out,
  output reg         rx_erasure_out,
  output reg         rx_blank_out,
  output reg         rx_strobe_out,
  // status
  output reg         running_out,
  output reg         init_busy_out,
  output reg         audio_mute_out,
  output reg  [2:0]  mode_out,
  output reg         narrowband_out
);

  localparam ST_IDLE = 2'h0;
  localparam ST_INIT = 2'h1;
  localparam ST_RUN  = 2'h2;

  // spacing load counts frame ticks; the extra tick keeps a full frame period
  // between switches even when a switch lands just before a tick
  localparam [31:0] SWITCH_LOAD = `SWITCH_FRAMES + 1;
  localparam [31:0] MUTE_LOAD   = MUTE_FRAMES;

  reg [1:0]  state_reg;
  reg [1:0]  state_next;
  reg [25:0] cycle_reg;
  reg        frame_tick_reg;
  reg [25:0] init_cnt_reg;
  reg        action_seen_reg;
  reg        instance_seen_reg;
  reg        pend_valid_reg;
  reg [2:0]  pend_mode_reg;
  reg        pend_peer_reg;
  reg        pend_reinit_reg;
  reg        peer_reg;
  reg [7:0]  mute_cnt_reg;
  reg [7:0]  switch_cnt_reg;
  reg        overflow_reg;
  reg [2:0]  type_next;
  wire       start_connect;
  wire       apply_msg;
  wire       do_reinit;
  wire       fifo_ready;
  wire       ones_next;
  wire [12:0] fifo_out;

  // payload length for a packet type
  function [8:0] type_bits;
    input [2:0] t;
    begin
      case (t)
        `PKT_FULL:    type_bits = `BITS_FULL;
        `PKT_HALF:    type_bits = `BITS_HALF;
        `PKT_QUARTER: type_bits = `BITS_QUARTER;
        `PKT_EIGHTH:  type_bits = `BITS_EIGHTH;
        default:      type_bits = `BITS_BLANK;
      endcase
    end
  endfunction

  // rate chosen from speech class and mode; half-rate-max mode never exceeds half
  // silent frames go out at eighth rate unless blank_cmd_in is set, which keeps the average low in every mode
  function [2:0] pick_rate;
    input [1:0] cls;
    input [1:0] mode;
    begin
      case (cls)
        `CLASS_SILENT:   pick_rate = `PKT_EIGHTH;
        `CLASS_UNVOICED: pick_rate = (mode == 2'h0) ? `PKT_HALF : `PKT_QUARTER;
        `CLASS_VOICED:   pick_rate = (mode == `MODE_HRMAX) ? `PKT_HALF :
                                     (mode == 2'h2) ? `PKT_HALF : `PKT_FULL;
        default:         pick_rate = (mode == `MODE_HRMAX) ? `PKT_HALF : `PKT_FULL;
      endcase
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // connection start and reinit decode
  // both events are latched while idle so either order starts the codec
  assign start_connect = (state_reg == ST_IDLE) &
                         (action_seen_reg | action_time_in) &
                         (instance_seen_reg | call_instance_in);
  assign apply_msg     = pend_valid_reg & action_time_in & (state_reg != ST_IDLE);
  assign do_reinit     = apply_msg & pend_reinit_reg;

  //////////////////////////////////////////////////////////////////////////////
  // state machine next state
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: if (start_connect) state_next = ST_INIT;
      ST_INIT: if (init_cnt_reg == INIT_CYCLES - 1) state_next = ST_RUN;
      ST_RUN:  if (do_reinit) state_next = ST_INIT;
      default: state_next = ST_IDLE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // state, init timer and connection event latches
  always @(posedge clock_in)
  begin
    if (rst_in)
    begin
      state_reg         <= ST_IDLE;
      init_cnt_reg      <= 26'h0000000;
      action_seen_reg   <= 1'b0;
      instance_seen_reg <= 1'b0;
    end
    else
    begin
      // a reinit from run goes back through init; idle is left only once
      state_reg <= state_next;
      if (state_reg == ST_INIT)
        init_cnt_reg <= init_cnt_reg + 26'h0000001;
      else
        init_cnt_reg <= 26'h0000000;
      // remember whichever event came first so the later one starts the codec
      if (state_reg == ST_IDLE)
      begin
        action_seen_reg   <= action_seen_reg | action_time_in;
        instance_seen_reg <= instance_seen_reg | call_instance_in;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // frame pacing: free-running 20 ms tick once running
  // the counter restarts on each entry to run, so the first frame is a full period
  always @(posedge clock_in)
  begin
    if (rst_in || state_reg != ST_RUN)
    begin
      cycle_reg      <= 26'h0000000;
      frame_tick_reg <= 1'b0;
    end
    else
    begin
      frame_tick_reg <= (cycle_reg == FRAME_CYCLES - 1);
      if (cycle_reg == FRAME_CYCLES - 1)
        cycle_reg <= 26'h0000000;
      else
        cycle_reg <= cycle_reg + 26'h0000001;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // control message holding, mode, mute and switch spacing
  always @(posedge clock_in)
  begin
    if (rst_in)
    begin
      pend_valid_reg  <= 1'b0;
      pend_mode_reg   <= `MODE_RESET;
      pend_peer_reg   <= 1'b0;
      pend_reinit_reg <= 1'b0;
      peer_reg        <= 1'b0;
      mode_out        <= `MODE_RESET;
      narrowband_out  <= 1'b0;
      mute_cnt_reg    <= 8'h00;
      switch_cnt_reg  <= 8'h00;
      audio_mute_out  <= 1'b0;
    end
    else
    begin
      // a new message overwrites the single pending slot; arrival beats the apply
      if (ctrl_msg_valid_in)
      begin
        pend_valid_reg  <= 1'b1;
        pend_mode_reg   <= encoding_mode_select_in;
        pend_peer_reg   <= peer_mobile_flag_in;
        pend_reinit_reg <= reinit_flag_in;
      end
      else if (apply_msg)
        pend_valid_reg <= 1'b0;
      if (frame_tick_reg && switch_cnt_reg != 8'h00)
        switch_cnt_reg <= switch_cnt_reg - 8'h01;
      // entering init clears the mode and frees the spacing window for the first switch
      if (state_next == ST_INIT && state_reg != ST_INIT)
      begin
        mode_out       <= `MODE_RESET;
        narrowband_out <= 1'b0;
        switch_cnt_reg <= 8'h00;
      end
      else if (apply_msg && pend_mode_reg != mode_out && switch_cnt_reg == 8'h00)
      begin
        // a switch inside the spacing window is dropped, the old mix stays
        mode_out       <= pend_mode_reg;
        narrowband_out <= pend_mode_reg[`MODE_NB_BIT];
        switch_cnt_reg <= SWITCH_LOAD[7:0];
      end
      if (apply_msg)
        peer_reg <= pend_peer_reg;
      // mute runs one second of frames after init when the peer flag is held
      if (state_reg == ST_INIT && state_next == ST_RUN)
        mute_cnt_reg <= (peer_reg | (apply_msg & pend_peer_reg)) ? MUTE_LOAD[7:0] : 8'h00;
      else if (frame_tick_reg && mute_cnt_reg != 8'h00)
        mute_cnt_reg <= mute_cnt_reg - 8'h01;
      audio_mute_out <= (mute_cnt_reg != 8'h00) | (state_reg != ST_RUN);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // per-frame transmit type selection
  // priority: blank, then the idle filler, then the half-rate cap
  always @*
  begin
    type_next = pick_rate(speech_class_in, mode_out[1:0]);
    if (blank_cmd_in)
      type_next = `PKT_BLANK;
    else if (!conversation_in)
      type_next = `PKT_EIGHTH;
    else if (rate_limit_cmd_in && type_next == `PKT_FULL)
      type_next = `PKT_HALF;
  end

  // descriptor is type, all-ones flag and payload length; a full fifo drops and flags
  // dropping keeps the frame grid intact; the sticky flag reports that a frame was lost
  always @(posedge clock_in)
  begin
    if (rst_in)
      overflow_reg <= 1'b0;
    else if (frame_tick_reg && !fifo_ready)
      overflow_reg <= 1'b1;
  end

  // outside conversation the filler eighth-rate frame is sent with every bit set;
  // blank wins over it because type_next is already blank then
  assign ones_next = (type_next == `PKT_EIGHTH) & ~conversation_in;

  // one push per tick; the fifo depth bounds how long the sublayer may stall
  packet_fifo #(
    .WIDTH (13),
    .DEPTH (4),
    .AW    (2)
  ) tx_fifo (
    .clock_in      (clock_in),
    .rst_in        (rst_in),
    .in_valid_in   (frame_tick_reg),
    .in_ready_out  (fifo_ready),
    .in_data_in    ({ones_next, type_next, type_bits(type_next)}),
    .out_valid_out (tx_valid_out),
    .out_ready_in  (tx_ready_in),
    .out_data_out  (fifo_out)
  );

  // descriptor fields: all-ones flag, type, payload length
  assign tx_type_out     = fifo_out[11:9];
  assign tx_bits_out     = fifo_out[8:0];
  assign tx_all_ones_out = fifo_out[12];
  assign tx_overflow_out = overflow_reg;

  //////////////////////////////////////////////////////////////////////////////
  // received packet classification; processed in every state, strobed only in run
  // erasure and blank carry no payload, so their length reads zero
  always @(posedge clock_in)
  begin
    if (rst_in)
    begin
      rx_bits_out    <= 9'h000;
      rx_erasure_out <= 1'b0;
      rx_blank_out   <= 1'b0;
      rx_strobe_out  <= 1'b0;
      running_out    <= 1'b0;
      init_busy_out  <= 1'b0;
    end
    else
    begin
      rx_strobe_out  <= rx_valid_in & (state_reg == ST_RUN);
      if (rx_valid_in)
      begin
        rx_bits_out    <= type_bits(rx_type_in);
        rx_erasure_out <= (rx_type_in == `PKT_ERASURE);
        rx_blank_out   <= (rx_type_in == `PKT_BLANK);
      end
      running_out   <= (state_reg == ST_RUN);
      init_busy_out <= (state_reg == ST_INIT);
    end
  end

endmodule // speech_packet_rate_interface

`default_nettype wire

// ==== sim/mux_sublayer_model.sv ====
// behavioural multiplex sublayer: drains outgoing descriptors, delivers received types
// assumes inputs change just after the rising edge
`timescale 1ns/100ps
`default_nettype none
module mux_sublayer_model (
  // clock
  input wire logic       clock_in,
  // control from the bench
  input wire logic       stall_in,
  // outgoing descriptors
  input wire logic       tx_valid_in,
  input wire logic [2:0] tx_type_in,
  input wire logic [8:0] tx_bits_in,
  input wire logic       tx_all_ones_in,
  output logic           tx_ready_out,
  // received packets
  output logic           rx_valid_out,
  output logic [2:0]     rx_type_out
);
  logic [2:0] last_type;
  logic [8:0] last_bits;
  logic       last_ones;
  int         tx_count = 0;
  initial rx_valid_out = 1'b0;
  initial rx_type_out = 3'h7;
  // a stalled sublayer simply refuses descriptors
  assign tx_ready_out = !stall_in;
  // record each accepted descriptor
  always @(posedge clock_in)
    if (tx_valid_in && tx_ready_out)
    begin
      last_type <= tx_type_in;
      last_bits <= tx_bits_in;
      last_ones <= tx_all_ones_in;
      tx_count  <= tx_count + 1;
    end
  // one frame type per call; blank only for blank-and-burst frames
  task send_rx(input [2:0] t);
    @(posedge clock_in);
    #1 rx_valid_out = 1'b1;
    rx_type_out = t;
    @(posedge clock_in);
    #1 rx_valid_out = 1'b0;
    rx_type_out = ~t; // released field does not keep its value
  endtask
endmodule // mux_sublayer_model
`default_nettype wire

// ==== sim/speech_packet_props.sv ====
// port assertions for the speech packet rate block
// assumes one clock and a synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
`include "speech_packet_regs.vh"
module speech_packet_props #(
  parameter INIT_CYCLES = 20
) (
  // clock and reset
  input wire logic       clock_in,
  input wire logic       rst_in,
  // watched ports
  input wire logic       rx_valid_in,
  input wire logic [2:0] rx_type_in,
  input wire logic       tx_valid_out,
  input wire logic [2:0] tx_type_out,
  input wire logic [8:0] tx_bits_out,
  input wire logic       tx_all_ones_out,
  input wire logic       tx_overflow_out,
  input wire logic [8:0] rx_bits_out,
  input wire logic       rx_erasure_out,
  input wire logic       rx_blank_out,
  input wire logic       rx_strobe_out,
  input wire logic       running_out,
  input wire logic       init_busy_out,
  input wire logic       audio_mute_out,
  input wire logic [2:0] mode_out,
  input wire logic       narrowband_out
);
  logic [31:0] busy_cnt_reg;
  // payload length per type, kept apart from the design's own table
  function automatic [8:0] size_of(input [2:0] t);
    case (t)
      `PKT_FULL:    size_of = 9'h10a;
      `PKT_HALF:    size_of = 9'h07c;
      `PKT_QUARTER: size_of = 9'h036;
      `PKT_EIGHTH:  size_of = 9'h014;
      default:      size_of = 9'h000;
    endcase
  endfunction
  // length of the current init phase in cycles
  always @(posedge clock_in)
    if (rst_in || !init_busy_out)
      busy_cnt_reg <= 32'h0;
    else
      busy_cnt_reg <= busy_cnt_reg + 32'h1;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  ////////////////////////////////////////
  a_init_mode_zero: assert property ($rose(init_busy_out) |-> ##[0:1] (mode_out == 3'h0 && !narrowband_out))
    else $error("init did not clear the mode");
  a_init_bounded: assert property (busy_cnt_reg <= INIT_CYCLES + 1)
    else $error("init phase too long");
  a_bits_table: assert property (tx_valid_out |-> tx_bits_out == size_of(tx_type_out))
    else $error("payload length does not match type");
  a_tx_type_legal: assert property (tx_valid_out |-> tx_type_out <= `PKT_BLANK)
    else $error("illegal outgoing type");
  a_ones_eighth: assert property (tx_valid_out && tx_all_ones_out |-> tx_type_out == `PKT_EIGHTH)
    else $error("all-ones flag on a non-eighth packet");
  a_rx_strobe: assert property (rx_valid_in && running_out |=> rx_strobe_out ##1 !rx_strobe_out)
    else $error("received packet not strobed once");
  a_rx_erasure: assert property (rx_valid_in && running_out && rx_type_in == `PKT_ERASURE |=>
    rx_erasure_out && !rx_blank_out && rx_bits_out == 9'h000)
    else $error("erasure not reported");
  a_rx_blank: assert property (rx_valid_in && running_out && rx_type_in == `PKT_BLANK |=>
    rx_blank_out && !rx_erasure_out && rx_bits_out == 9'h000)
    else $error("blank not reported");
  a_rx_bits: assert property (rx_valid_in && running_out && rx_type_in < `PKT_BLANK |=>
    rx_bits_out == size_of($past(rx_type_in)) && !rx_erasure_out)
    else $error("received length wrong");
  a_mute_on_stop: assert property ($fell(running_out) |=> audio_mute_out)
    else $error("audio not muted when stopped");
  a_overflow_sticky: assert property (tx_overflow_out |=> tx_overflow_out)
    else $error("overflow flag cleared");
endmodule // speech_packet_props
`default_nettype wire

// ==== sim/speech_packet_rate_interface_tb.sv ====
// self-checking bench for the speech packet rate block
// assumes shortened frame, init and mute counts
`timescale 1ns/100ps
`default_nettype none
`include "speech_packet_regs.vh"
module speech_packet_rate_interface_tb;
  localparam FRAME = 50;
  logic clock_in = 1'b0, rst_in = 1'b1, stall = 1'b0;
  logic action_time_in = 1'b0, call_instance_in = 1'b0, conversation_in = 1'b0;
  logic blank_cmd_in = 1'b0, rate_limit_cmd_in = 1'b0, ctrl_msg_valid_in = 1'b0;
  logic peer_mobile_flag_in = 1'b0, reinit_flag_in = 1'b0;
  logic [1:0] speech_class_in = 2'h0;
  logic [2:0] encoding_mode_select_in = 3'h0;
  wire tx_valid_out, tx_ready_in, tx_all_ones_out, tx_overflow_out, rx_valid_in, rx_erasure_out;
  wire rx_blank_out, rx_strobe_out, running_out, init_busy_out, audio_mute_out, narrowband_out;
  wire [2:0] tx_type_out, rx_type_in, mode_out;
  wire [8:0] tx_bits_out, rx_bits_out;
  int err_total = 0, tests_run = 0, k, n;
  always #12.5 clock_in = ~clock_in;
  speech_packet_rate_interface #(.FRAME_CYCLES(FRAME), .INIT_CYCLES(20), .MUTE_FRAMES(3))
    u_speech_packet_rate_interface (.clock_in, .rst_in, .action_time_in, .call_instance_in,
    .conversation_in, .blank_cmd_in, .rate_limit_cmd_in, .speech_class_in, .ctrl_msg_valid_in,
    .encoding_mode_select_in, .peer_mobile_flag_in, .reinit_flag_in, .tx_valid_out, .tx_ready_in,
    .tx_type_out, .tx_bits_out, .tx_all_ones_out, .tx_overflow_out, .rx_valid_in, .rx_type_in,
    .rx_bits_out, .rx_erasure_out, .rx_blank_out, .rx_strobe_out, .running_out, .init_busy_out,
    .audio_mute_out, .mode_out, .narrowband_out);
  mux_sublayer_model u_mux_sublayer_model (.clock_in, .stall_in(stall), .tx_valid_in(tx_valid_out),
    .tx_type_in(tx_type_out), .tx_bits_in(tx_bits_out), .tx_all_ones_in(tx_all_ones_out),
    .tx_ready_out(tx_ready_in),
    .rx_valid_out(rx_valid_in), .rx_type_out(rx_type_in));
  wire [2:0] got_type = u_mux_sublayer_model.last_type;
  wire [8:0] got_bits = u_mux_sublayer_model.last_bits;
  wire       got_ones = u_mux_sublayer_model.last_ones;
  ////////////////////////////////////////
  task chk(input [8:0] got, input [8:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("checks=%0d mismatches=%0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task tick(input int c);
    repeat (c) @(posedge clock_in);
    #1;
  endtask
  // bounded wait for the next accepted descriptor
  task next_pkt;
    n = u_mux_sublayer_model.tx_count;
    for (k = 0; k < 4 * FRAME && u_mux_sublayer_model.tx_count == n; k++) tick(1);
    if (k == 4 * FRAME)
    begin
      err_total++;
      test_done;
    end
  endtask
  task wait_run;
    for (k = 0; k < 30 && running_out !== 1'b1; k++) tick(1);
    chk(running_out, 9'h1);
  endtask
  // latch a control message, then apply it with an action time pulse
  task send_msg(input [2:0] m, input p, input r);
    encoding_mode_select_in = m;
    peer_mobile_flag_in = p;
    reinit_flag_in = r;
    ctrl_msg_valid_in = 1'b1;
    tick(1);
    ctrl_msg_valid_in = 1'b0;
    action_time_in = 1'b1;
    tick(1);
    action_time_in = 1'b0;
    tick(3);
  endtask
  ////////////////////////////////////////
  task t_start;
    call_instance_in = 1'b1;
    tick(5);
    chk(init_busy_out | running_out, 9'h0);
    action_time_in = 1'b1;
    tick(1);
    action_time_in = 1'b0;
    tick(2);
    chk(init_busy_out, 9'h1);
    wait_run;
    chk({narrowband_out, mode_out}, 9'h0);
    $display("t_start done");
  endtask
  task t_idle;
    next_pkt;
    blank_cmd_in = 1'b1;
    next_pkt;
    chk({got_type, got_bits}, {`PKT_BLANK, 9'h000});
    chk(got_ones, 9'h0);
    blank_cmd_in = 1'b0;
    rate_limit_cmd_in = 1'b1;
    next_pkt;
    chk({got_type, got_bits}, {`PKT_EIGHTH, 9'h014});
    chk(got_ones, 9'h1);
    $display("t_idle done");
  endtask
  task t_conv;
    conversation_in = 1'b1;
    for (int c = 0; c < 8; c++)
    begin
      speech_class_in = c[1:0];
      rate_limit_cmd_in = c[2];
      next_pkt;
      chk(got_type <= `PKT_EIGHTH, 9'h1);
      chk(c[2] && got_type == `PKT_FULL, 9'h0);
      chk(got_ones, 9'h0);
    end
    blank_cmd_in = 1'b1;
    next_pkt;
    chk({got_type, got_bits}, {`PKT_BLANK, 9'h000});
    blank_cmd_in = 1'b0;
    rate_limit_cmd_in = 1'b0;
    $display("t_conv done");
  endtask
  task t_rx;
    for (int t = 0; t < 6; t++)
    begin
      u_mux_sublayer_model.send_rx(t[2:0]);
      chk({rx_strobe_out, rx_erasure_out, rx_blank_out}, {1'b1, t == 5, t == 4});
      chk(rx_bits_out, t == 0 ? 9'h10a : t == 1 ? 9'h07c : t == 2 ? 9'h036 : t == 3 ? 9'h014 : 9'h000);
    end
    $display("t_rx done");
  endtask
  task t_mode;
    conversation_in = 1'b0; // the first switch is applied outside conversation; the design does not gate switches on conversation_in
    next_pkt;
    send_msg(3'h5, 1'b0, 1'b0);
    chk({narrowband_out, mode_out}, {1'b1, 3'h5});
    conversation_in = 1'b1;
    send_msg(3'h6, 1'b0, 1'b0);
    chk(mode_out, 9'h5);
    next_pkt;
    next_pkt;
    send_msg(3'h7, 1'b0, 1'b0);
    chk({narrowband_out, mode_out}, {1'b1, 3'h7});
    speech_class_in = `CLASS_VOICED;
    next_pkt;
    next_pkt;
    chk(got_type == `PKT_FULL, 9'h0);
    $display("t_mode done");
  endtask
  task t_reinit;
    send_msg(3'h0, 1'b1, 1'b1);
    chk(running_out, 9'h0);
    wait_run;
    chk({audio_mute_out, narrowband_out, mode_out}, {1'b1, 1'b0, 3'h0});
    next_pkt;
    chk(audio_mute_out, 9'h1);
    repeat (3) next_pkt;
    chk(audio_mute_out, 9'h0);
    $display("t_reinit done");
  endtask
  task t_fifo;
    stall = 1'b1;
    for (k = 0; k < 7 * FRAME && tx_overflow_out !== 1'b1; k++) tick(1);
    chk(tx_overflow_out, 9'h1);
    n = u_mux_sublayer_model.tx_count;
    stall = 1'b0;
    tick(10);
    chk(u_mux_sublayer_model.tx_count - n, 9'h4);
    chk(tx_valid_out, 9'h0);
    n = u_mux_sublayer_model.tx_count;
    tick(3 * FRAME);
    chk(u_mux_sublayer_model.tx_count - n, 9'h3);
    $display("t_fifo done");
  endtask
  initial
  begin
    tick(6);
    rst_in = 1'b0;
    t_start;
    t_idle;
    t_conv;
    t_rx;
    t_mode;
    t_reinit;
    t_fifo;
    test_done;
  end
endmodule // speech_packet_rate_interface_tb
bind speech_packet_rate_interface speech_packet_props #(.INIT_CYCLES(INIT_CYCLES)) u_speech_packet_props (
  .clock_in, .rst_in, .rx_valid_in, .rx_type_in, .tx_valid_out, .tx_type_out, .tx_bits_out,
  .tx_overflow_out, .tx_all_ones_out, .rx_bits_out, .rx_erasure_out, .rx_blank_out, .rx_strobe_out, .running_out,
  .init_busy_out, .audio_mute_out, .mode_out, .narrowband_out);
`default_nettype wire
